// ==== hw/twoc_timer.v ====
// 8-bit timer with waveform generation, two compare outputs and an APB slave
// Functional notes
// - Nonzero channel A output mode connects compare output A to its pin.
// - Nonzero channel B output mode connects compare output B to its pin.
// - Non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM A: 10 clears on match, sets at TOP; 11 inverse.
// - PWM A mode 01 toggles on match only when mode high bit set.
// - Phase-correct A: 10 clears on up match, sets on down; 11 inverse.
// - Fast PWM B: 01 reserved; 10 clear match/set TOP; 11 inverse.
// - Phase-correct B: 01 reserved; 10 clear up/set down; 11 inverse.
// - PWM compare equal TOP with mode high bit: match ignored, TOP action kept.
// - Waveform mode picks operation and TOP; 100 and 110 reserved.
// - Overflow flag at MAX in 0,2,3; BOTTOM in 1,5; TOP in 7.
// - Waveform mode is control A bits 1:0 plus control B bit 3.
// - Force bits give one forced match in non-PWM modes only.
// - Forced match sets no flag and never clears the counter.
// - Force bits always read zero.
// - Control A bits 3 and 2 read zero.
// - Control B bits 5 and 4 read zero.
// - Clock source selects stop, divided I/O clock or external edges.
// - A counter write suppresses compare match on the next timer clock.
// - Compare flag sets when counter equals compare value.
// - Flags clear by writing one, or by interrupt acknowledge.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "twoc_consts.vh"
module twoc_timer (
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_count_in,
  input wire ack_cmp_a,
  input wire ack_cmp_b,
  input wire ack_ovf,
  output reg compare_output_a,
  output reg compare_output_b,
  output reg pin_override_a,
  output reg pin_override_b,
  output reg compare_flag_a,
  output reg compare_flag_b,
  output reg overflow_flag
);
  reg [7:0] ctrl_a_r;
  reg [3:0] ctrl_b_r;
  reg [7:0] count_r;
  reg [7:0] cmp_a_buf_r;
  reg [7:0] cmp_b_buf_r;
  reg [7:0] cmp_a_r;
  reg [7:0] cmp_b_r;
  reg down_r;
  reg block_r;
  reg [9:0] presc_r;
  reg ext_s1_r;
  reg ext_s2_r;
  reg ext_d_r;
  reg oc_a_r;
  reg oc_b_r;
  reg [7:0] count_nxt;
  reg down_nxt;
  reg oc_a_nxt;
  reg oc_b_nxt;
  reg tick;
  reg [31:0] rd_val;
  reg addr_ok;

  wire [2:0] wmode = {ctrl_b_r[`TWOC_CB_WGM_TOP],
                      ctrl_a_r[`TWOC_CA_WGM_HI:`TWOC_CA_WGM_LO]};
  wire [1:0] mode_a = ctrl_a_r[`TWOC_CA_MODE_A_HI:`TWOC_CA_MODE_A_LO];
  wire [1:0] mode_b = ctrl_a_r[`TWOC_CA_MODE_B_HI:`TWOC_CA_MODE_B_LO];
  wire [2:0] csel = ctrl_b_r[`TWOC_CB_CS_HI:`TWOC_CB_CS_LO];
  wire is_fast = (wmode == `TWOC_WM_FAST_FF) || (wmode == `TWOC_WM_FAST_CMP);
  wire is_pc = (wmode == `TWOC_WM_PC_FF) || (wmode == `TWOC_WM_PC_CMP);
  wire is_pwm = is_fast || is_pc;
  wire is_nonpwm = (wmode == `TWOC_WM_NORMAL) || (wmode == `TWOC_WM_CTC);
  // TOP source per waveform mode
  wire top_from_a = (wmode == `TWOC_WM_CTC) || (wmode == `TWOC_WM_PC_CMP) ||
                    (wmode == `TWOC_WM_FAST_CMP);
  wire [7:0] top = top_from_a ? cmp_a_r : `TWOC_MAX;
  wire at_top = (count_r == top);
  wire wr_en = psel && penable && pwrite && pready;
  wire wr_ctrl_b = wr_en && (paddr == `TWOC_OFF_CTRL_B);
  wire wr_count = wr_en && (paddr == `TWOC_OFF_COUNT);
  wire wr_flags = wr_en && (paddr == `TWOC_OFF_FLAGS);
  wire wr_presc = wr_en && (paddr == `TWOC_OFF_PRESC_CLR);
  // Compare hits, blocked after a counter write
  wire hit_a = tick && !block_r && (count_r == cmp_a_r);
  wire hit_b = tick && !block_r && (count_r == cmp_b_r);
  // PWM ignores a match where compare equals TOP with high mode bit
  wire ign_a = is_pwm && mode_a[1] && (cmp_a_r == top);
  wire ign_b = is_pwm && mode_b[1] && (cmp_b_r == top);
  wire wave_a = hit_a && !ign_a;
  wire wave_b = hit_b && !ign_b;
  // Force strobes act only in non-PWM modes
  wire force_a = wr_ctrl_b && pwdata[`TWOC_CB_FORCE_A] && is_nonpwm;
  wire force_b = wr_ctrl_b && pwdata[`TWOC_CB_FORCE_B] && is_nonpwm;
  wire fast_top = tick && is_fast && at_top;
  reg ovf_ev;

  // Prescaler runs free, so the first divided tick may come early
  // Timer clock select: prescaler taps and synchronised external edges
  always @* begin
    case (csel)
      3'h0: tick = 1'b0;
      3'h1: tick = 1'b1;
      3'h2: tick = (presc_r[`TWOC_DIV8_TAP:0] == 3'h7);
      3'h3: tick = (presc_r[`TWOC_DIV64_TAP:0] == 6'h3f);
      3'h4: tick = (presc_r[`TWOC_DIV256_TAP:0] == 8'hff);
      3'h5: tick = (presc_r[`TWOC_DIV1024_TAP:0] == 10'h3ff);
      3'h6: tick = ext_d_r && !ext_s2_r;
      3'h7: tick = !ext_d_r && ext_s2_r;
      default: tick = 1'b0;
    endcase
  end

  // Counting sequence
  always @* begin
    count_nxt = count_r;
    down_nxt = down_r;
    if (tick) begin
      if (is_pc) begin
        if (!down_r) begin
          if (at_top) begin
            down_nxt = 1'b1;
            count_nxt = count_r - 8'h01;
          end else begin
            count_nxt = count_r + 8'h01;
          end
        end else begin
          if (count_r == `TWOC_BOTTOM) begin
            down_nxt = 1'b0;
            count_nxt = count_r + 8'h01;
          end else begin
            count_nxt = count_r - 8'h01;
          end
        end
      end else if (top_from_a && at_top) begin
        count_nxt = `TWOC_BOTTOM;
        down_nxt = 1'b0;
      end else begin
        count_nxt = count_r + 8'h01;
        down_nxt = 1'b0;
      end
    end
    if (wr_count) begin
      count_nxt = pwdata[7:0];
    end
  end

  // Overflow event per waveform mode
  always @* begin
    case (wmode)
      `TWOC_WM_NORMAL, `TWOC_WM_CTC, `TWOC_WM_FAST_FF: ovf_ev = tick && (count_r == `TWOC_MAX);
      `TWOC_WM_PC_FF, `TWOC_WM_PC_CMP: ovf_ev = tick && (count_r == `TWOC_BOTTOM);
      `TWOC_WM_FAST_CMP: ovf_ev = tick && at_top;
      default: ovf_ev = 1'b0;
    endcase
  end

  // Compare output A waveform
  always @* begin
    oc_a_nxt = oc_a_r;
    if (is_nonpwm) begin
      if (wave_a || force_a) begin
        case (mode_a)
          2'h1: oc_a_nxt = !oc_a_r;
          2'h2: oc_a_nxt = 1'b0;
          2'h3: oc_a_nxt = 1'b1;
          default: oc_a_nxt = oc_a_r;
        endcase
      end
    end else if (is_pwm) begin
      if (mode_a == 2'h1) begin
        if (wave_a && ctrl_b_r[`TWOC_CB_WGM_TOP]) begin
          oc_a_nxt = !oc_a_r;
        end
      end else if (mode_a[1]) begin
        if (is_fast) begin
          if (fast_top) begin
            oc_a_nxt = !mode_a[0];
          end else if (wave_a) begin
            oc_a_nxt = mode_a[0];
          end
        end else if (wave_a) begin
          oc_a_nxt = down_r ? !mode_a[0] : mode_a[0];
        // Compare pinned at TOP settles to the down-count level
        end else if (tick && at_top && ign_a) begin
          oc_a_nxt = !mode_a[0];
        end
      end
    end
  end

  // Compare output B waveform; mode 01 reserved in PWM
  always @* begin
    oc_b_nxt = oc_b_r;
    if (is_nonpwm) begin
      if (wave_b || force_b) begin
        case (mode_b)
          2'h1: oc_b_nxt = !oc_b_r;
          2'h2: oc_b_nxt = 1'b0;
          2'h3: oc_b_nxt = 1'b1;
          default: oc_b_nxt = oc_b_r;
        endcase
      end
    end else if (is_pwm && mode_b[1]) begin
      if (is_fast) begin
        if (fast_top) begin
          oc_b_nxt = !mode_b[0];
        end else if (wave_b) begin
          oc_b_nxt = mode_b[0];
        end
      end else if (wave_b) begin
        oc_b_nxt = down_r ? !mode_b[0] : mode_b[0];
      end else if (tick && at_top && ign_b) begin
        oc_b_nxt = !mode_b[0];
      end
    end
  end

  // Read mux; force bits and reserved bits read as zero
  always @* begin
    rd_val = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      `TWOC_OFF_CTRL_A: rd_val = {24'h000000, ctrl_a_r[7:4], 2'h0, ctrl_a_r[1:0]};
      `TWOC_OFF_CTRL_B: rd_val = {24'h000000, 4'h0, ctrl_b_r};
      `TWOC_OFF_COUNT: rd_val = {24'h000000, count_r};
      `TWOC_OFF_CMP_A: rd_val = {24'h000000, cmp_a_buf_r};
      `TWOC_OFF_CMP_B: rd_val = {24'h000000, cmp_b_buf_r};
      `TWOC_OFF_FLAGS: rd_val = {28'h0000000, compare_flag_b, compare_flag_a, overflow_flag, 1'b0};
      `TWOC_OFF_PRESC_CLR: rd_val = 32'h0000_0000;
      default: addr_ok = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_a_r <= `TWOC_CTRL_A_RST;
      ctrl_b_r <= 4'h0;
      count_r <= 8'h00;
      cmp_a_buf_r <= 8'h00;
      cmp_b_buf_r <= 8'h00;
      cmp_a_r <= 8'h00;
      cmp_b_r <= 8'h00;
      down_r <= 1'b0;
      block_r <= 1'b0;
      presc_r <= 10'h000;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r <= 1'b0;
      oc_a_r <= 1'b0;
      oc_b_r <= 1'b0;
      compare_output_a <= 1'b0;
      compare_output_b <= 1'b0;
      pin_override_a <= 1'b0;
      pin_override_b <= 1'b0;
      compare_flag_a <= 1'b0;
      compare_flag_b <= 1'b0;
      overflow_flag <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_val;
      end
      presc_r <= wr_presc ? 10'h000 : presc_r + 10'h001;
      ext_s1_r <= ext_count_in;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
      if (wr_en && paddr == `TWOC_OFF_CTRL_A) begin
        ctrl_a_r <= pwdata[7:0];
      end
      if (wr_ctrl_b) begin
        ctrl_b_r <= pwdata[3:0];
      end
      if (wr_en && paddr == `TWOC_OFF_CMP_A) begin
        cmp_a_buf_r <= pwdata[7:0];
      end
      if (wr_en && paddr == `TWOC_OFF_CMP_B) begin
        cmp_b_buf_r <= pwdata[7:0];
      end
      // Working compare copies
      if (!is_pwm || (tick && at_top)) begin
        cmp_a_r <= cmp_a_buf_r;
        cmp_b_r <= cmp_b_buf_r;
      end
      count_r <= count_nxt;
      down_r <= down_nxt;
      if (wr_count) begin
        block_r <= 1'b1;
      end else if (tick) begin
        block_r <= 1'b0;
      end
      oc_a_r <= oc_a_nxt;
      oc_b_r <= oc_b_nxt;
      compare_output_a <= oc_a_nxt;
      compare_output_b <= oc_b_nxt;
      pin_override_a <= (mode_a != 2'h0);
      pin_override_b <= (mode_b != 2'h0);
      // Set wins over clear; forced matches never reach flags
      if (hit_a) begin
        compare_flag_a <= 1'b1;
      end else if (ack_cmp_a || (wr_flags && pwdata[`TWOC_FL_CMP_A])) begin
        compare_flag_a <= 1'b0;
      end
      if (hit_b) begin
        compare_flag_b <= 1'b1;
      end else if (ack_cmp_b || (wr_flags && pwdata[`TWOC_FL_CMP_B])) begin
        compare_flag_b <= 1'b0;
      end
      if (ovf_ev) begin
        overflow_flag <= 1'b1;
      end else if (ack_ovf || (wr_flags && pwdata[`TWOC_FL_OVF])) begin
        overflow_flag <= 1'b0;
      end
    end
  end
endmodule // twoc_timer
`default_nettype wire

// ==== hw/twoc_consts.vh ====
// Register offsets, field positions and fixed values for the waveform timer
`ifndef TWOC_CONSTS_VH
`define TWOC_CONSTS_VH
`define TWOC_OFF_CTRL_A 12'h000
`define TWOC_OFF_CTRL_B 12'h004
`define TWOC_OFF_COUNT 12'h008
`define TWOC_OFF_CMP_A 12'h00c
`define TWOC_OFF_CMP_B 12'h010
`define TWOC_OFF_FLAGS 12'h014
`define TWOC_OFF_PRESC_CLR 12'h018
`define TWOC_CA_MODE_A_HI 7
`define TWOC_CA_MODE_A_LO 6
`define TWOC_CA_MODE_B_HI 5
`define TWOC_CA_MODE_B_LO 4
`define TWOC_CA_WGM_HI 1
`define TWOC_CA_WGM_LO 0
`define TWOC_CB_FORCE_A 7
`define TWOC_CB_FORCE_B 6
`define TWOC_CB_WGM_TOP 3
`define TWOC_CB_CS_HI 2
`define TWOC_CB_CS_LO 0
`define TWOC_FL_CMP_B 3
`define TWOC_FL_CMP_A 2
`define TWOC_FL_OVF 1
`define TWOC_CTRL_A_RST 8'h00
`define TWOC_CTRL_B_RST 8'h00
`define TWOC_MAX 8'hff
`define TWOC_BOTTOM 8'h00
`define TWOC_WM_NORMAL 3'h0
`define TWOC_WM_PC_FF 3'h1
`define TWOC_WM_CTC 3'h2
`define TWOC_WM_FAST_FF 3'h3
`define TWOC_WM_PC_CMP 3'h5
`define TWOC_WM_FAST_CMP 3'h7
`define TWOC_DIV8_TAP 2
`define TWOC_DIV64_TAP 5
`define TWOC_DIV256_TAP 7
`define TWOC_DIV1024_TAP 9
`endif

// ==== verif/twoc_timer_props.sv ====
// Concurrent checks on the waveform timer ports
`timescale 1ns/1ps
`default_nettype none
module twoc_timer_props (
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire compare_output_a,
  input wire compare_output_b,
  input wire pin_override_a,
  input wire pin_override_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_acc;
    psel && penable && pready;
  endsequence
  sequence s_wr_a;
    s_acc ##0 (pwrite && paddr == 12'h000);
  endsequence
  sequence s_rd_a;
    s_acc ##0 (!pwrite && paddr == 12'h000);
  endsequence
  sequence s_rd_b;
    s_acc ##0 (!pwrite && paddr == 12'h004);
  endsequence
  ovr_a_follow_a: assert property (s_wr_a |-> ##2
    pin_override_a == (|$past(pwdata[7:6], 2))) else $error("override a wrong");
  ovr_b_follow_a: assert property (s_wr_a |-> ##2
    pin_override_b == (|$past(pwdata[5:4], 2))) else $error("override b wrong");
  rsv_a_zero_a: assert property (s_rd_a |-> prdata[3:2] == 2'h0)
    else $error("ctrl a reserved bits set");
  rsv_b_zero_a: assert property (s_rd_b |-> prdata[5:4] == 2'h0)
    else $error("ctrl b reserved bits set");
  force_rd_zero_a: assert property (s_rd_b |-> prdata[7:6] == 2'h0)
    else $error("force bits read one");
  rst_out_low_a: assert property ($rose(rstn) |-> !compare_output_a && !compare_output_b)
    else $error("outputs high after reset");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // twoc_timer_props
bind twoc_timer twoc_timer_props u_props (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .compare_output_a(compare_output_a),
  .compare_output_b(compare_output_b), .pin_override_a(pin_override_a),
  .pin_override_b(pin_override_b));
`default_nettype wire

// ==== verif/twoc_timer_bench.sv ====
// Self-checking bench for the waveform timer
`timescale 1ns/1ps
`default_nettype none
module twoc_timer_bench;
  logic clk, rstn, psel, penable, pwrite, ext_count_in, ack_cmp_a, ack_cmp_b, ack_ovf;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, oa, ob, pov_a, pov_b, fa, fb, fov, err;
  int failures, checked, h, hb, e;
  logic [7:0] cfg [4] = '{8'ha3, 8'hf3, 8'ha1, 8'hf1};
  logic [1:0] fm [4] = '{2'h1, 2'h1, 2'h3, 2'h2};
  twoc_timer u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_in(ext_count_in), .ack_cmp_a(ack_cmp_a),
    .ack_cmp_b(ack_cmp_b), .ack_ovf(ack_ovf), .compare_output_a(oa),
    .compare_output_b(ob), .pin_override_a(pov_a), .pin_override_b(pov_b),
    .compare_flag_a(fa), .compare_flag_b(fb), .overflow_flag(fov));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task close_out;
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, x);
    end
  endtask
  // One APB transfer, then a few idle cycles so outputs settle
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    repeat (3) @(posedge clk);
  endtask
  // Counts high cycles of both outputs over a fixed window
  task duty;
    h = 0;
    hb = 0;
    repeat (1020) begin
      @(posedge clk);
      h += oa;
      hb += ob;
    end
  endtask
  initial begin
    #1000000;
    failures++;
    close_out;
  end
  initial begin
    {rstn, psel, penable, pwrite, ext_count_in, ack_cmp_a, ack_cmp_b, ack_ovf} = 0;
    paddr = 0;
    pwdata = 0;
    repeat (16) @(posedge clk);
    rstn <= 1;
    xfer(0, 12'h000, 0);
    chk(rd, 0);
    xfer(1, 12'h004, 32'hf8);
    xfer(0, 12'h004, 0);
    chk(rd, 32'h08);
    xfer(1, 12'h000, 32'hff);
    xfer(0, 12'h000, 0);
    chk(rd, 32'hf3);
    chk({pov_a, pov_b}, 2'h3);
    xfer(1, 12'h004, 0);
    xfer(1, 12'h000, 0);
    chk({pov_a, pov_b}, 2'h0);
    xfer(0, 12'h020, 0);
    chk(err, 1);
    chk(rd, 0);
    // Forced matches walk toggle, toggle, set, clear with the counter stopped
    for (int k = 0; k < 4; k++) begin
      xfer(1, 12'h000, {24'h0, fm[k], fm[k], 4'h0});
      xfer(1, 12'h004, 32'hc0);
      chk({oa, ob}, {2{k % 2 == 0}});
    end
    chk({fa, fb, fov}, 0);
    xfer(1, 12'h000, 32'hf3);
    xfer(1, 12'h004, 32'hc0);
    chk({oa, ob}, 0);
    xfer(1, 12'h000, 0);
    xfer(1, 12'h008, 32'hfd);
    xfer(1, 12'h004, 32'h01);
    repeat (8) @(posedge clk);
    xfer(1, 12'h004, 0);
    chk(fov, 1);
    chk({fa, fb}, 2'h3);
    ack_ovf <= 1;
    ack_cmp_a <= 1;
    @(posedge clk);
    ack_ovf <= 0;
    ack_cmp_a <= 0;
    repeat (2) @(posedge clk);
    chk({fov, fa, fb}, 3'h1);
    xfer(1, 12'h014, 32'h08);
    chk({fa, fb}, 0);
    // Duty of each PWM flavour, compare value a quarter of full scale
    xfer(1, 12'h00c, 32'h40);
    xfer(1, 12'h010, 32'h40);
    for (int k = 0; k < 4; k++) begin
      xfer(1, 12'h000, {24'h0, cfg[k]});
      xfer(1, 12'h004, 32'h01);
      repeat (600) @(posedge clk);
      duty;
      e = cfg[k][6] ? 764 : 256;
      chk(h > e - 12 && h < e + 12, 1);
      chk(hb > e - 12 && hb < e + 12, 1);
      xfer(1, 12'h004, 0);
    end
    // Clear-on-match with TOP from compare A: counter never reaches MAX
    xfer(1, 12'h000, 32'h42);
    xfer(1, 12'h00c, 32'h10);
    xfer(1, 12'h008, 0);
    xfer(1, 12'h014, 32'h0e);
    xfer(1, 12'h004, 32'h01);
    repeat (200) @(posedge clk);
    xfer(0, 12'h008, 0);
    chk(rd < 32'h11, 1);
    xfer(1, 12'h004, 0);
    chk({fa, fb, fov}, 3'h4);
    // Fast PWM with TOP from compare A, channel A toggling on match
    xfer(1, 12'h00c, 32'h3f);
    xfer(1, 12'h010, 32'h1f);
    xfer(1, 12'h008, 0);
    xfer(1, 12'h014, 32'h0e);
    xfer(1, 12'h000, 32'h63);
    xfer(1, 12'h004, 32'h09);
    repeat (300) @(posedge clk);
    duty;
    chk(h > 498 && h < 522, 1);
    chk(hb > 498 && hb < 522, 1);
    xfer(1, 12'h004, 0);
    chk({fa, fb, fov}, 3'h7);
    ack_cmp_b <= 1;
    @(posedge clk);
    ack_cmp_b <= 0;
    repeat (2) @(posedge clk);
    chk({fa, fb, fov}, 3'h5);
    // Divide-by-8 prescaler tap, then rising edges on the external input
    xfer(1, 12'h000, 0);
    xfer(1, 12'h008, 0);
    xfer(1, 12'h018, 0);
    xfer(1, 12'h004, 32'h02);
    repeat (80) @(posedge clk);
    xfer(1, 12'h004, 0);
    xfer(0, 12'h008, 0);
    chk(rd >= 9 && rd <= 12, 1);
    xfer(1, 12'h008, 0);
    xfer(1, 12'h004, 32'h07);
    repeat (5) begin
      ext_count_in <= 1;
      repeat (4) @(posedge clk);
      ext_count_in <= 0;
      repeat (4) @(posedge clk);
    end
    xfer(1, 12'h004, 0);
    xfer(0, 12'h008, 0);
    chk(rd, 5);
    // A counter write hides the match on the next tick
    xfer(1, 12'h00c, 32'h05);
    xfer(1, 12'h014, 32'h0e);
    xfer(1, 12'h008, 32'h05);
    xfer(1, 12'h004, 32'h01);
    xfer(1, 12'h004, 0);
    chk(fa, 0);
    xfer(1, 12'h008, 32'h04);
    xfer(1, 12'h004, 32'h01);
    xfer(1, 12'h004, 0);
    chk(fa, 1);
    ack_cmp_a <= 1;
    @(posedge clk);
    ack_cmp_a <= 0;
    repeat (2) @(posedge clk);
    chk(fa, 0);
    // Mid-run reset returns outputs and flags to zero
    rstn <= 0;
    repeat (2) @(posedge clk);
    chk({oa, ob, pov_a, pov_b, fa, fb, fov}, 0);
    rstn <= 1;
    xfer(0, 12'h004, 0);
    chk(rd, 0);
    close_out;
  end
endmodule // twoc_timer_bench
`default_nettype wire
